// ### hw/rtc_timekeeping_interval_alarm.sv
// rtc_timekeeping_interval_alarm: time-of-day counters and 8-bit interval alarm
// assumes: I_XTAL_32K is the calibrated crystal clock, asynchronous to I_CLK_SYS;
// I_SFR_REQ, I_WARM_RST_N and I_RTC_RUN_EN come from logic on I_CLK_SYS
//
// How it works
// R01 - single shot 0: alarm flag set each interval, then counting restarts
// R02 - single shot 1: alarm flag set after one interval, no restart
// R03 - alarm flag at config bit 2, resets 0, write 0 clears, 1 ignored
// R04 - interval timer enable 0: interval counter held at zero
// R05 - interval timer runs only with its enable and rtc run enable set
// R06 - software keeps config bit 0 at 1 when writing config
// R07 - fractional counter ticks at 128 Hz from crystal, wraps 127 into seconds
// R08 - seconds wrap after 59 to 0 and advance minutes
// R09 - minutes wrap after 59 to 0 and advance hours
// R10 - 24-hour mode: hours wrap 23 to 0, set midnight, post interrupt
// R11 - 256-hour mode: hours wrap 255 to 0, set midnight, post interrupt
// R12 - time counters survive warm reset, cleared only by power-on reset
// R13 - interval counter advances on selected tick; match sets alarm, posts interrupt
// R14 - interval counter is eight bits, at most 256 ticks (interval value 0)
// R15 - software unlocks with key value before time writes, then zeroes key
// R16 - midnight flag stays set until software clears it or a warm or power-on reset
// R17 - two-bit timebase select: 1/128 s, second, minute or hour tick
// R18 - unlocked write loads a time counter at once, counting resumes next tick
`timescale 1ns/1ps
`default_nettype none

module rtc_timekeeping_interval_alarm
  import rtc_pkg::*;
#(
  parameter int unsigned PRESCALE = XTAL_PER_TICK
) (
  input  wire logic     I_CLK_SYS,
  input  wire logic     I_RST_N,
  input  wire logic     I_WARM_RST_N,
  input  wire logic     I_XTAL_32K,
  input  wire logic     I_RTC_RUN_EN,
  input  wire sfr_req_t I_SFR_REQ,
  output var  logic [7:0] O_SFR_RDATA,
  output var  logic     O_RTC_IRQ,
  output var  logic     O_MIDNIGHT,
  output var  logic     O_ALARM
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [8:0] step(input logic [7:0] v, input logic [7:0] last);
    if (v >= last) begin
      return {1'b1, COUNTER_RESET};
    end
    return {1'b0, 8'(v + 8'h01)};
  endfunction

  localparam int unsigned PW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;
  localparam logic [PW-1:0] PRESCALE_LAST = PW'(PRESCALE - 1);

  logic            any_rst;
  logic            xtal_s1;
  logic            xtal_s2;
  logic            xtal_s3;
  logic            xtal_rise;
  logic [PW-1:0]   presc;
  logic [7:0]      frac;
  logic [7:0]      sec;
  logic [7:0]      min;
  logic [7:0]      hour;
  logic [7:0]      interval;
  logic [7:0]      key;
  logic [7:0]      icnt;
  logic            twenty_four_hour_select;
  logic [1:0]      interval_timebase_select;
  logic            single_shot_select;
  logic            interval_timer_enable;
  logic            rsvd;
  logic            midnight;
  logic            alarm;
  interval_state_t istate;
  logic            frac_tick;
  logic            sec_tick;
  logic            min_tick;
  logic            hour_tick;
  logic            frac_wrap;
  logic            sec_wrap;
  logic            min_wrap;
  logic            hour_wrap;
  logic [7:0]      next_frac;
  logic [7:0]      next_sec;
  logic [7:0]      next_min;
  logic [7:0]      next_hour;
  logic [7:0]      next_icnt;
  logic [7:0]      hour_last;
  logic            tb_tick;
  logic            run;
  logic            alarm_hit;
  logic            midnight_hit;
  logic            unlocked;
  logic            wr_cfg;

  assign any_rst = !I_RST_N || !I_WARM_RST_N;
  assign unlocked = (key == KEY_UNLOCK);
  assign wr_cfg = I_SFR_REQ.wr && (I_SFR_REQ.addr == ADDR_CONFIG);

  //////////////////////////////////////////////////////////////////////////////
  // crystal synchroniser and 128 Hz prescaler
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      xtal_s1 <= 1'b0;
      xtal_s2 <= 1'b0;
      xtal_s3 <= 1'b0;
    end else begin
      xtal_s1 <= I_XTAL_32K;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
    end
  end

  assign xtal_rise = xtal_s2 && !xtal_s3;

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      presc <= '0;
    end else if (xtal_rise) begin
      presc <= (presc == PRESCALE_LAST) ? '0 : PW'(presc + 1'b1);
    end
  end

  assign frac_tick = xtal_rise && (presc == PRESCALE_LAST); // [R07]

  //////////////////////////////////////////////////////////////////////////////
  // carry chain
  assign hour_last = twenty_four_hour_select ? HOUR_LAST_24 : HOUR_LAST_256; // [R10] [R11]
  assign {frac_wrap, next_frac} = step(frac, FRAC_LAST); // [R07]
  assign {sec_wrap, next_sec} = step(sec, SEC_LAST); // [R08]
  assign {min_wrap, next_min} = step(min, MIN_LAST); // [R09]
  assign {hour_wrap, next_hour} = step(hour, hour_last);
  assign sec_tick = frac_tick && frac_wrap; // [R07]
  assign min_tick = sec_tick && sec_wrap; // [R08]
  assign hour_tick = min_tick && min_wrap; // [R09]
  assign midnight_hit = hour_tick && hour_wrap; // [R10] [R11]

  //////////////////////////////////////////////////////////////////////////////
  // time counters, power-on reset only
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      frac <= COUNTER_RESET; // [R12]
    end else if (I_SFR_REQ.wr && unlocked && I_SFR_REQ.addr == ADDR_FRAC) begin
      frac <= I_SFR_REQ.wdata; // [R18] [R15]
    end else if (frac_tick) begin
      frac <= next_frac;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      sec <= COUNTER_RESET; // [R12]
    end else if (I_SFR_REQ.wr && unlocked && I_SFR_REQ.addr == ADDR_SEC) begin
      sec <= I_SFR_REQ.wdata; // [R18]
    end else if (sec_tick) begin
      sec <= next_sec;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      min <= COUNTER_RESET; // [R12]
    end else if (I_SFR_REQ.wr && unlocked && I_SFR_REQ.addr == ADDR_MIN) begin
      min <= I_SFR_REQ.wdata; // [R18]
    end else if (min_tick) begin
      min <= next_min;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      hour <= COUNTER_RESET; // [R12]
    end else if (I_SFR_REQ.wr && unlocked && I_SFR_REQ.addr == ADDR_HOUR) begin
      hour <= I_SFR_REQ.wdata; // [R18]
    end else if (hour_tick) begin
      hour <= next_hour;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration, key and interval registers
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      twenty_four_hour_select <= 1'b0;
    end else if (wr_cfg) begin
      twenty_four_hour_select <= I_SFR_REQ.wdata[CFG_HOUR_MODE];
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (any_rst) begin
      interval_timebase_select <= TB_FRAC;
      single_shot_select       <= 1'b0;
      interval_timer_enable    <= 1'b0;
      rsvd                     <= RSVD_RESET; // [R06]
    end else if (wr_cfg) begin
      interval_timebase_select <= I_SFR_REQ.wdata[CFG_TIMEBASE_HI:CFG_TIMEBASE_LO];
      single_shot_select       <= I_SFR_REQ.wdata[CFG_SINGLE_SHOT];
      interval_timer_enable    <= I_SFR_REQ.wdata[CFG_TIMER_EN];
      rsvd                     <= I_SFR_REQ.wdata[CFG_RSVD];
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (any_rst) begin
      key <= 8'h00;
    end else if (I_SFR_REQ.wr && I_SFR_REQ.addr == ADDR_KEY) begin
      key <= I_SFR_REQ.wdata; // [R15]
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (any_rst) begin
      interval <= COUNTER_RESET;
    end else if (I_SFR_REQ.wr && I_SFR_REQ.addr == ADDR_INTERVAL) begin
      interval <= I_SFR_REQ.wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interval timer
  always_comb begin
    case (timebase_t'(interval_timebase_select)) // [R17]
      TB_FRAC: tb_tick = frac_tick;
      TB_SEC:  tb_tick = sec_tick;
      TB_MIN:  tb_tick = min_tick;
      default: tb_tick = hour_tick;
    endcase
  end

  assign run = interval_timer_enable && I_RTC_RUN_EN; // [R05]
  assign next_icnt = 8'(icnt + 8'h01); // [R14]
  assign alarm_hit = (istate == IT_RUN) && run && tb_tick && (next_icnt == interval); // [R13]

  always_ff @(posedge I_CLK_SYS) begin
    if (any_rst || !interval_timer_enable) begin
      istate <= IT_IDLE;
      icnt   <= COUNTER_RESET; // [R04]
    end else begin
      case (istate)
        IT_IDLE: begin
          if (run) begin
            istate <= IT_RUN;
          end
        end
        IT_RUN: begin
          if (!run) begin
            istate <= IT_IDLE; // [R05]
          end else if (alarm_hit) begin
            icnt <= COUNTER_RESET; // [R01]
            if (single_shot_select) begin
              istate <= IT_DONE; // [R02]
            end
          end else if (tb_tick) begin
            icnt <= next_icnt; // [R13]
          end
        end
        IT_DONE: begin
          istate <= IT_DONE; // [R02]
        end
        default: begin
          istate <= IT_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event flags, set wins over clear
  always_ff @(posedge I_CLK_SYS) begin
    if (any_rst) begin
      alarm <= 1'b0;
    end else if (alarm_hit) begin
      alarm <= 1'b1; // [R01] [R13]
    end else if (wr_cfg && !I_SFR_REQ.wdata[CFG_ALARM]) begin
      alarm <= 1'b0; // [R03]
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (any_rst) begin
      midnight <= 1'b0;
    end else if (midnight_hit) begin
      midnight <= 1'b1; // [R10] [R11]
    end else if (wr_cfg && !I_SFR_REQ.wdata[CFG_MIDNIGHT]) begin
      midnight <= 1'b0; // [R16]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge I_CLK_SYS) begin
    if (any_rst) begin
      O_RTC_IRQ  <= 1'b0;
      O_MIDNIGHT <= 1'b0;
      O_ALARM    <= 1'b0;
    end else begin
      O_RTC_IRQ  <= alarm_hit || midnight_hit; // [R10] [R13]
      O_MIDNIGHT <= midnight || midnight_hit;
      O_ALARM    <= alarm || alarm_hit;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      O_SFR_RDATA <= 8'h00;
    end else if (I_SFR_REQ.addr == ADDR_CONFIG) begin
      O_SFR_RDATA <= {midnight, twenty_four_hour_select, interval_timebase_select,
                      single_shot_select, alarm, interval_timer_enable, rsvd};
    end else if (I_SFR_REQ.addr == ADDR_FRAC) begin
      O_SFR_RDATA <= frac;
    end else if (I_SFR_REQ.addr == ADDR_SEC) begin
      O_SFR_RDATA <= sec;
    end else if (I_SFR_REQ.addr == ADDR_MIN) begin
      O_SFR_RDATA <= min;
    end else if (I_SFR_REQ.addr == ADDR_HOUR) begin
      O_SFR_RDATA <= hour;
    end else if (I_SFR_REQ.addr == ADDR_INTERVAL) begin
      O_SFR_RDATA <= interval;
    end else if (I_SFR_REQ.addr == ADDR_KEY) begin
      O_SFR_RDATA <= key;
    end else begin
      O_SFR_RDATA <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ### hw/rtc_pkg.sv
// rtc_pkg: constants, types and register map of the timekeeping and interval alarm block
// assumes: one system clock, registers reached by byte-wide special function register accesses
package rtc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // timebase
  localparam int unsigned XTAL_HZ       = 32768;
  localparam int unsigned TICK_HZ       = 128;
  localparam int unsigned XTAL_PER_TICK = XTAL_HZ / TICK_HZ;

  //////////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [7:0] ADDR_CONFIG   = 8'hA1;
  localparam logic [7:0] ADDR_FRAC     = 8'hA2;
  localparam logic [7:0] ADDR_SEC      = 8'hA3;
  localparam logic [7:0] ADDR_MIN      = 8'hA4;
  localparam logic [7:0] ADDR_HOUR     = 8'hA5;
  localparam logic [7:0] ADDR_INTERVAL = 8'hA6;
  localparam logic [7:0] ADDR_KEY      = 8'hC1;
  localparam logic [7:0] KEY_UNLOCK    = 8'hEA;

  //////////////////////////////////////////////////////////////////////////////
  // configuration fields
  localparam int unsigned CFG_MIDNIGHT    = 7;
  localparam int unsigned CFG_HOUR_MODE   = 6;
  localparam int unsigned CFG_TIMEBASE_HI = 5;
  localparam int unsigned CFG_TIMEBASE_LO = 4;
  localparam int unsigned CFG_SINGLE_SHOT = 3;
  localparam int unsigned CFG_ALARM       = 2;
  localparam int unsigned CFG_TIMER_EN    = 1;
  localparam int unsigned CFG_RSVD        = 0;
  localparam logic        RSVD_RESET      = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // reset values and wrap points
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] FRAC_LAST     = 8'h7F;
  localparam logic [7:0] SEC_LAST      = 8'h3B;
  localparam logic [7:0] MIN_LAST      = 8'h3B;
  localparam logic [7:0] HOUR_LAST_24  = 8'h17;
  localparam logic [7:0] HOUR_LAST_256 = 8'hFF;

  //////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    TB_FRAC = 2'h0,
    TB_SEC  = 2'h1,
    TB_MIN  = 2'h2,
    TB_HOUR = 2'h3
  } timebase_t;

  typedef enum logic [2:0] {
    IT_IDLE = 3'h1,
    IT_RUN  = 3'h2,
    IT_DONE = 3'h4
  } interval_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage

// ### test/rtc_timekeeping_interval_alarm_chk.sv
// rtc_timekeeping_interval_alarm_chk: port assertions for the rtc block
// assumes: bound to the top module, one clock, power-on reset active low
`timescale 1ns/1ps
`default_nettype none
module rtc_timekeeping_interval_alarm_chk
  import rtc_pkg::*;
(
  input wire logic       I_CLK_SYS,
  input wire logic       I_RST_N,
  input wire logic       I_WARM_RST_N,
  input wire sfr_req_t   I_SFR_REQ,
  input wire logic [7:0] O_SFR_RDATA,
  input wire logic       O_RTC_IRQ,
  input wire logic       O_MIDNIGHT,
  input wire logic       O_ALARM
);
  logic [1:0] irq_d;
  logic       cfg_d;
  logic       warm_d;
  wire logic  cfg_wr = I_SFR_REQ.wr && I_SFR_REQ.addr == ADDR_CONFIG;
  wire logic  near   = O_RTC_IRQ || irq_d != 2'h0;
  wire logic  quiet  = !cfg_wr && !cfg_d && I_WARM_RST_N && warm_d;
  default clocking dc @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  ////////////////////////////////////////
  // recent irq, config write and warm reset history
  always_ff @(posedge I_CLK_SYS) begin
    irq_d  <= {irq_d[0], O_RTC_IRQ};
    cfg_d  <= cfg_wr;
    warm_d <= I_WARM_RST_N;
  end
  sequence int_wr;
    I_SFR_REQ.wr && I_SFR_REQ.addr == ADDR_INTERVAL && I_WARM_RST_N;
  endsequence
  sequence int_hold;
    !I_SFR_REQ.wr && I_SFR_REQ.addr == ADDR_INTERVAL && I_WARM_RST_N;
  endsequence
  ////////////////////////////////////////
  a_irq_one_pulse: assert property (O_RTC_IRQ |=> !O_RTC_IRQ)
    else $error("irq pulse longer than one cycle");
  a_irq_has_cause: assert property (O_RTC_IRQ |-> (O_ALARM || O_MIDNIGHT))
    else $error("irq without alarm or midnight flag");
  a_alarm_posts_irq: assert property ($rose(O_ALARM) |-> ##[0:2] near)
    else $error("alarm set without irq");
  a_midnight_posts_irq: assert property ($rose(O_MIDNIGHT) |-> ##[0:2] near)
    else $error("midnight set without irq");
  a_alarm_sw_clear: assert property (cfg_wr && !I_SFR_REQ.wdata[CFG_ALARM] && O_ALARM |-> ##[1:2] (!O_ALARM || near))
    else $error("alarm not cleared by write of 0");
  a_alarm_not_set: assert property (cfg_wr && I_SFR_REQ.wdata[CFG_ALARM] && !O_ALARM |-> ##2 (!O_ALARM || near))
    else $error("alarm set by write of 1");
  a_alarm_holds: assert property (O_ALARM && quiet |=> O_ALARM)
    else $error("alarm dropped without clear");
  a_midnight_holds: assert property (O_MIDNIGHT && quiet |=> O_MIDNIGHT)
    else $error("midnight dropped without clear");
  a_interval_readback: assert property (int_wr ##1 int_hold |=> O_SFR_RDATA == $past(I_SFR_REQ.wdata, 2))
    else $error("interval value not read back");
endmodule

bind rtc_timekeeping_interval_alarm rtc_timekeeping_interval_alarm_chk u_chk (
  .I_CLK_SYS    (I_CLK_SYS),
  .I_RST_N      (I_RST_N),
  .I_WARM_RST_N (I_WARM_RST_N),
  .I_SFR_REQ    (I_SFR_REQ),
  .O_SFR_RDATA  (O_SFR_RDATA),
  .O_RTC_IRQ    (O_RTC_IRQ),
  .O_MIDNIGHT   (O_MIDNIGHT),
  .O_ALARM      (O_ALARM)
);
`default_nettype wire

// ### test/tb_rtc_timekeeping_interval_alarm.sv
// tb_rtc_timekeeping_interval_alarm: self-checking bench for the rtc block
// assumes: rtc_pkg, the design and the bound checker compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_timekeeping_interval_alarm
  import rtc_pkg::*;
;
  localparam int unsigned PS = 2;
  logic       clk, rst_n, warm_n, xtal, run_en, irq, mid, alarm;
  sfr_req_t   req;
  logic [7:0] rdata;
  int         error_cnt = 0;
  int         compares = 0;
  int         cyc = 0;
  int         irq_cnt = 0;

  rtc_timekeeping_interval_alarm #(.PRESCALE(PS)) DUT (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_WARM_RST_N(warm_n), .I_XTAL_32K(xtal),
    .I_RTC_RUN_EN(run_en), .I_SFR_REQ(req), .O_SFR_RDATA(rdata), .O_RTC_IRQ(irq),
    .O_MIDNIGHT(mid), .O_ALARM(alarm));
  ////////////////////////////////////////
  // bus, crystal and compare helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{a, 1'b1, d};
    @(posedge clk) req <= '{a, 1'b0, 8'h00};
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) req <= '{a, 1'b0, 8'h00};
    repeat (2) @(posedge clk);
    #1 chk("rdata", e, rdata);
  endtask
  task automatic uw(input logic [7:0] a, input logic [7:0] d);
    wr(ADDR_KEY, KEY_UNLOCK);
    wr(a, d);
    wr(ADDR_KEY, 8'h00);
  endtask
  task automatic preset(input logic [7:0] f, input logic [7:0] s, input logic [7:0] m, input logic [7:0] h);
    uw(ADDR_FRAC, f);
    uw(ADDR_SEC, s);
    uw(ADDR_MIN, m);
    uw(ADDR_HOUR, h);
  endtask
  task automatic tick(input int n);
    repeat (n * PS) begin
      @(posedge clk) xtal <= 1'b1;
      repeat (3) @(posedge clk);
      xtal <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic al(input logic e);
    chk("alarm", 8'(e), 8'(alarm));
  endtask
  task automatic ic(input int e);
    chk("irq count", 8'(e), 8'(irq_cnt));
    irq_cnt = 0;
  endtask
  ////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    rd(ADDR_CONFIG, 8'h01);
    for (int i = 2; i < 7; i++) rd(8'hA0 + 8'(i), 8'h00);
    rd(8'h50, 8'h00);
    ic(0);
  endtask
  task automatic t_lock();
    wr(ADDR_SEC, 8'h1E);
    rd(ADDR_SEC, 8'h00);
    uw(ADDR_SEC, 8'h1E);
    rd(ADDR_SEC, 8'h1E);
  endtask
  task automatic t_rollover();
    uw(ADDR_FRAC, 8'h7F);
    tick(1);
    rd(ADDR_SEC, 8'h1F);
    rd(ADDR_FRAC, 8'h00);
    wr(ADDR_CONFIG, 8'h41);
    preset(8'h7F, 8'h3B, 8'h3B, 8'h17);
    tick(1);
    chk("mid", 8'h01, 8'(mid));
    ic(1);
    rd(ADDR_SEC, 8'h00);
    rd(ADDR_MIN, 8'h00);
    rd(ADDR_HOUR, 8'h00);
    tick(1);
    chk("mid", 8'h01, 8'(mid));
    wr(ADDR_CONFIG, 8'h41);
    rd(ADDR_CONFIG, 8'h41);
  endtask
  task automatic t_warm();
    uw(ADDR_HOUR, 8'h0A);
    wr(ADDR_CONFIG, 8'h53);
    wr(ADDR_INTERVAL, 8'h55);
    @(posedge clk) warm_n <= 1'b0;
    @(posedge clk) warm_n <= 1'b1;
    rd(ADDR_HOUR, 8'h0A);
    rd(ADDR_FRAC, 8'h01);
    rd(ADDR_CONFIG, 8'h41);
    rd(ADDR_INTERVAL, 8'h00);
  endtask
  task automatic t_256();
    wr(ADDR_CONFIG, 8'h01);
    preset(8'h7F, 8'h3B, 8'h3B, 8'hFF);
    tick(1);
    chk("mid", 8'h01, 8'(mid));
    ic(1);
    rd(ADDR_HOUR, 8'h00);
    wr(ADDR_CONFIG, 8'h01);
  endtask
  task automatic t_interval();
    wr(ADDR_INTERVAL, 8'h03);
    @(posedge clk) run_en <= 1'b1;
    wr(ADDR_CONFIG, 8'h03);
    tick(2);
    al(1'b0);
    tick(1);
    al(1'b1);
    ic(1);
    wr(ADDR_CONFIG, 8'h03);
    wr(ADDR_CONFIG, 8'h07);
    rd(ADDR_CONFIG, 8'h03);
    tick(2);
    al(1'b0);
    tick(1);
    al(1'b1);
    wr(ADDR_CONFIG, 8'h01);
    wr(ADDR_CONFIG, 8'h0B);
    tick(3);
    al(1'b1);
    wr(ADDR_CONFIG, 8'h0B);
    tick(3);
    al(1'b0);
    ic(2);
    wr(ADDR_CONFIG, 8'h01);
    wr(ADDR_CONFIG, 8'h03);
    tick(2);
    wr(ADDR_CONFIG, 8'h01);
    wr(ADDR_CONFIG, 8'h03);
    tick(2);
    al(1'b0);
    tick(1);
    al(1'b1);
    wr(ADDR_CONFIG, 8'h03);
    @(posedge clk) run_en <= 1'b0;
    tick(3);
    al(1'b0);
    @(posedge clk) run_en <= 1'b1;
    tick(3);
    al(1'b1);
    ic(2);
  endtask
  task automatic t_timebase();
    wr(ADDR_INTERVAL, 8'h01);
    for (int ts = 1; ts < 4; ts++) begin
      wr(ADDR_CONFIG, 8'h01);
      preset((ts == 1) ? 8'h7E : 8'h7F, (ts == 2) ? 8'h3A : 8'h3B, 8'h3A, 8'h00);
      wr(ADDR_CONFIG, {2'h0, 2'(ts), 4'h3});
      tick(1);
      al(1'b0);
      preset(8'h7F, (ts == 1) ? 8'h3A : 8'h3B, (ts == 2) ? 8'h3A : 8'h3B, 8'h00);
      tick(1);
      al(1'b1);
      ic(1);
    end
  endtask
  task automatic close_out();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // clock, timeout and main sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(negedge clk) begin
    if (irq === 1'b1) begin
      irq_cnt++;
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    rst_n  = 1'b0;
    warm_n = 1'b1;
    xtal   = 1'b0;
    run_en = 1'b0;
    req    = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_lock();
    t_rollover();
    t_warm();
    t_256();
    t_interval();
    t_timebase();
    close_out();
  end
endmodule
`default_nettype wire
